// *** hdl/rut_timer_bank.sv ***
// Notes on behaviour
// - three independent timers, each a 16-bit auto-reloading counter
// - prescaler divides by a power of two from 1 to 128
// - counter counts up and starts from 0001h
// - counting runs to the reload value, then returns to 0001h
// - after reload the mode decides between stopping and going on
// - reload 0001h with prescale 1 times out after one clock
// - reload 0000h gives a full 65536-count period
// - counter at FFFFh wraps to 0000h on its next advance
// - reload below count: run through FFFFh, wrap, then match
// - timer 0 alternate inputs, when timer0_alt_enable is set, are ORed into its single input
// - each timer drives a complementary pair of output pins
// - external input counts events, gates the clock or captures
// - single-shot: on match raise interrupt, reload 0001h, disable
// - continuous: on match raise interrupt, reload 0001h, keep going
`timescale 1ns/100ps
`default_nettype none

module rut_timer_bank
    import rut_pkg::*;
(
    // clock and reset
    input  wire logic                                  clk,
    input  wire logic                                  resetn,
    // per-timer enable and mode
    input  wire logic      [NUM_TIMERS-1:0]            timer_start,
    input  wire logic      [NUM_TIMERS-1:0]            timer_stop,
    input  wire rut_mode_t [NUM_TIMERS-1:0]            timer_mode,
    input  wire logic      [NUM_TIMERS-1:0][PRE_SEL_W-1:0] prescale_sel,
    input  wire logic      [NUM_TIMERS-1:0]            polarity,
    // per-timer values
    input  wire logic      [NUM_TIMERS-1:0][CNT_W-1:0] reload_value,
    input  wire logic      [NUM_TIMERS-1:0][CNT_W-1:0] pwm_compare,
    input  wire logic      [NUM_TIMERS-1:0]            count_load,
    input  wire logic      [NUM_TIMERS-1:0][CNT_W-1:0] count_load_value,
    // external timer inputs
    input  wire logic                                  timer0_input_pin,
    input  wire logic                                  timer1_input_pin,
    input  wire logic                                  timer2_input_pin,
    // timer 0 alternate inputs
    input  wire logic                                  timer0_alt_input_a,
    input  wire logic                                  timer0_alt_input_b,
    input  wire logic                                  timer0_alt_input_c,
    input  wire logic                                  timer0_alt_enable,
    // status
    output logic           [NUM_TIMERS-1:0][CNT_W-1:0] count_value,
    output logic           [NUM_TIMERS-1:0][CNT_W-1:0] capture_value,
    output logic           [NUM_TIMERS-1:0]            timer_irq,
    output logic           [NUM_TIMERS-1:0]            timer_running,
    // timer output pins
    output logic           [NUM_TIMERS-1:0]            timer_out,
    output logic           [NUM_TIMERS-1:0]            timer_out_n
);

    // ----------
    // declarations
    // ----------
    rut_top_state_t        st;
    rut_top_state_t        next_st;

    logic [NUM_TIMERS-1:0] pri_level;
    logic [NUM_TIMERS-1:0] pri_rise;
    logic [NUM_TIMERS-1:0] pri_fall;
    logic [ALT_W-1:0]      alt_level;
    logic [ALT_W-1:0]      alt_rise;
    logic [ALT_W-1:0]      alt_fall;
    logic [NUM_TIMERS-1:0] in_level;
    logic [NUM_TIMERS-1:0] in_rise;
    logic [NUM_TIMERS-1:0] in_fall;
    logic [NUM_TIMERS-1:0] in_edge;
    logic [NUM_TIMERS-1:0] gate_open;
    logic [NUM_TIMERS-1:0] tick;
    logic [NUM_TIMERS-1:0] advance;
    logic [NUM_TIMERS-1:0] pre_restart;
    logic [NUM_TIMERS-1:0] pre_run;

    // ----------
    // input synchronisers
    // ----------

    // primary external inputs, one per timer
    rut_edge_sync #(
        .W (NUM_TIMERS)
    ) u_pri_sync (
        .clk    (clk),
        .resetn (resetn),
        .pin    ({timer2_input_pin, timer1_input_pin, timer0_input_pin}),
        .level  (pri_level),
        .rise   (pri_rise),
        .fall   (pri_fall)
    );

    // timer 0 alternate inputs
    rut_edge_sync #(
        .W (ALT_W)
    ) u_alt_sync (
        .clk    (clk),
        .resetn (resetn),
        .pin    ({timer0_alt_input_c, timer0_alt_input_b,
                  timer0_alt_input_a}),
        .level  (alt_level),
        .rise   (alt_rise),
        .fall   (alt_fall)
    );

    // ----------
    // input selection and advance sources
    // ----------

    // timer 0 merges its alternate inputs into its single input
    always_comb begin
        in_level = pri_level;
        in_rise  = pri_rise;
        in_fall  = pri_fall;
        if (timer0_alt_enable) begin
            in_level[0] = pri_level[0] | (|alt_level);
            in_rise[0]  = pri_rise[0]  | (|alt_rise);
            in_fall[0]  = pri_fall[0]  | (|alt_fall);
        end
    end

    // polarity picks the active edge and the active gate level
    genvar g;
    generate
        for (g = 0; g < NUM_TIMERS; g++) begin : g_chan
            rut_tick_if tk ();

            assign in_edge[g]   = polarity[g] ? in_fall[g]
                                              : in_rise[g];
            assign gate_open[g] = in_level[g] ^ polarity[g];

            // prescaler restarts on enable and on a trigger
            assign pre_restart[g] = timer_start[g]
                | ((st.ch[g].run == RUN_ARMED) & in_edge[g]);
            assign pre_run[g] = (st.ch[g].run == RUN_COUNT)
                & (timer_mode[g] != MODE_COUNTER)
                & ((timer_mode[g] != MODE_GATED) | gate_open[g]);

            assign tk.restart = pre_restart[g];
            assign tk.run     = pre_run[g];
            assign tk.shift   = prescale_sel[g];
            assign tick[g]    = tk.tick;

            rut_prescaler u_pre (
                .clk    (clk),
                .resetn (resetn),
                .tk     (tk)
            );

            // event counting bypasses the prescaler
            assign advance[g] = (timer_mode[g] == MODE_COUNTER)
                ? (in_edge[g] & (st.ch[g].run == RUN_COUNT))
                : tick[g];

            // outputs straight from the state register
            assign count_value[g]   = st.ch[g].count;
            assign capture_value[g] = st.ch[g].capture;
            assign timer_irq[g]     = st.ch[g].irq;
            assign timer_running[g] = st.ch[g].running;
            assign timer_out[g]     = st.ch[g].out;
            assign timer_out_n[g]   = st.ch[g].out_n;
        end
    endgenerate

    // ----------
    // channel state machines
    // ----------

    // one independent counter per timer
    always_comb begin
        next_st = st;
        for (int i = 0; i < NUM_TIMERS; i++) begin
            next_st.ch[i].irq = 1'b0;
            // single-shot outputs fall back to the idle level
            if (timer_mode[i] == MODE_ONE_SHOT
                || timer_mode[i] == MODE_TRIG_SHOT) begin
                next_st.ch[i].out = polarity[i];
            end
            if (timer_stop[i]) begin
                next_st.ch[i].run = RUN_IDLE;
            end else if (timer_start[i]) begin
                next_st.ch[i].out = polarity[i];
                if (timer_mode[i] == MODE_TRIG_SHOT) begin
                    next_st.ch[i].run = RUN_ARMED;
                end else begin
                    next_st.ch[i].run = RUN_COUNT;
                end
            end else begin
                case (st.ch[i].run)
                    RUN_IDLE: begin
                        next_st.ch[i].run = RUN_IDLE;
                    end
                    RUN_ARMED: begin
                        // wait for the trigger edge
                        if (in_edge[i]) begin
                            next_st.ch[i].run = RUN_COUNT;
                        end
                    end
                    RUN_COUNT: begin
                        // capture on an input edge
                        if (timer_mode[i] == MODE_CAPTURE
                            && in_edge[i]) begin
                            next_st.ch[i].capture = st.ch[i].count;
                            next_st.ch[i].irq     = 1'b1;
                        end
                        if (advance[i]) begin
                            if (st.ch[i].count == reload_value[i]) begin
                                next_st.ch[i].count = CNT_START;
                                next_st.ch[i].irq   = 1'b1;
                                case (timer_mode[i])
                                    MODE_ONE_SHOT: begin
                                        next_st.ch[i].run = RUN_IDLE;
                                        next_st.ch[i].out = ~polarity[i];
                                    end
                                    MODE_TRIG_SHOT: begin
                                        next_st.ch[i].run = RUN_ARMED;
                                        next_st.ch[i].out = ~polarity[i];
                                    end
                                    MODE_PWM: begin
                                        next_st.ch[i].out = polarity[i];
                                    end
                                    default: begin
                                        // continuous-type modes go on
                                        next_st.ch[i].out =
                                            ~st.ch[i].out;
                                    end
                                endcase
                            end else begin
                                // plain up-count, FFFFh wraps to 0000h
                                next_st.ch[i].count =
                                    st.ch[i].count + CNT_STEP;
                                if (timer_mode[i] == MODE_PWM
                                    && st.ch[i].count
                                       == pwm_compare[i]) begin
                                    next_st.ch[i].out = ~polarity[i];
                                end
                            end
                        end
                    end
                    default: begin
                        next_st.ch[i].run = RUN_IDLE;
                    end
                endcase
            end
            // software load of the starting count
            if (count_load[i]) begin
                next_st.ch[i].count = count_load_value[i];
            end
            next_st.ch[i].running = (next_st.ch[i].run == RUN_COUNT);
            next_st.ch[i].out_n   = ~next_st.ch[i].out;
        end
    end

    // ----------
    // state register
    // ----------

    // reset puts every counter at its start value
    always_ff @(posedge clk) begin
        if (!resetn) begin
            for (int i = 0; i < NUM_TIMERS; i++) begin
                st.ch[i] <= CHAN_RESET;
            end
        end else begin
            st <= next_st;
        end
    end

endmodule

`default_nettype wire

// *** hdl/rut_pkg.sv ***
package rut_pkg;

    // ----------
    // sizes
    // ----------
    localparam int NUM_TIMERS = 3;
    localparam int CNT_W      = 16;
    localparam int PRE_SEL_W  = 3;
    localparam int PRE_CNT_W  = 7;
    localparam int ALT_W      = 3;

    // ----------
    // values
    // ----------
    localparam logic [CNT_W-1:0]     CNT_START     = 16'h0001;
    localparam logic [CNT_W-1:0]     CNT_STEP      = 16'h0001;
    localparam logic [PRE_CNT_W-1:0] PRE_FULL_MASK = 7'h7f;
    localparam logic [PRE_CNT_W-1:0] PRE_STEP      = 7'h01;
    localparam logic [PRE_SEL_W-1:0] PRE_SEL_MAX   = 3'h7;

    // ----------
    // modes and states
    // ----------
    typedef enum logic [2:0] {
        MODE_ONE_SHOT   = 3'h0,
        MODE_CONTINUOUS = 3'h1,
        MODE_COUNTER    = 3'h2,
        MODE_PWM        = 3'h3,
        MODE_CAPTURE    = 3'h4,
        MODE_GATED      = 3'h5,
        MODE_TRIG_SHOT  = 3'h6
    } rut_mode_t;

    // gray sequence idle -> armed -> counting
    typedef enum logic [1:0] {
        RUN_IDLE  = 2'h0,
        RUN_ARMED = 2'h1,
        RUN_COUNT = 2'h3
    } rut_run_t;

    typedef struct packed {
        rut_run_t          run;
        logic              running;
        logic [CNT_W-1:0]  count;
        logic [CNT_W-1:0]  capture;
        logic              irq;
        logic              out;
        logic              out_n;
    } rut_chan_t;

    typedef struct packed {
        rut_chan_t [NUM_TIMERS-1:0] ch;
    } rut_top_state_t;

    typedef struct packed {
        logic [PRE_CNT_W-1:0] cnt;
    } rut_pre_state_t;

    localparam rut_chan_t CHAN_RESET = '{
        run:     RUN_IDLE,
        running: 1'b0,
        count:   CNT_START,
        capture: '0,
        irq:     1'b0,
        out:     1'b0,
        out_n:   1'b1
    };

endpackage

// *** hdl/rut_tick_if.sv ***
`timescale 1ns/100ps
`default_nettype none

// ----------
// control and tick between a timer channel and its prescaler
// ----------
interface rut_tick_if;
    import rut_pkg::*;
    logic                 restart;
    logic                 run;
    logic [PRE_SEL_W-1:0] shift;
    logic                 tick;

    modport ctrl (output restart, output run, output shift, input tick);
    modport div  (input restart, input run, input shift, output tick);
endinterface

`default_nettype wire

// *** hdl/rut_prescaler.sv ***
`timescale 1ns/100ps
`default_nettype none

// ----------
// divide-by-2^shift prescaler, one tick per period
// ----------
module rut_prescaler
    import rut_pkg::*;
(
    // clock and reset
    input  wire logic    clk,
    input  wire logic    resetn,
    // channel side
    rut_tick_if.div      tk
);

    rut_pre_state_t       st;
    rut_pre_state_t       next_st;
    logic [PRE_CNT_W-1:0] limit;

    // terminal count is divisor minus one
    assign limit   = PRE_FULL_MASK >> (PRE_SEL_MAX - tk.shift);
    assign tk.tick = tk.run & (st.cnt == limit);

    // next count: restart or tick clears, run advances, idle holds
    always_comb begin
        next_st = st;
        if (tk.restart) begin
            next_st.cnt = '0;
        end else if (tk.tick) begin
            next_st.cnt = '0;
        end else if (tk.run) begin
            next_st.cnt = st.cnt + PRE_STEP;
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule

`default_nettype wire

// *** hdl/rut_edge_sync.sv ***
`timescale 1ns/100ps
`default_nettype none

// ----------
// two-flop synchroniser with edge detect, W pins wide
// ----------
module rut_edge_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         resetn,
    // asynchronous pins
    input  wire logic [W-1:0] pin,
    // synchronised view
    output logic [W-1:0]      level,
    output logic [W-1:0]      rise,
    output logic [W-1:0]      fall
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
        logic [W-1:0] prev;
    } rut_sync_state_t;

    rut_sync_state_t st;
    rut_sync_state_t next_st;

    // only the second stage reads the first
    always_comb begin
        next_st      = st;
        next_st.meta = pin;
        next_st.sync = st.meta;
        next_st.prev = st.sync;
    end

    // state register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // edges from the settled stages
    assign level = st.sync;
    assign rise  = st.sync & ~st.prev;
    assign fall  = ~st.sync & st.prev;

endmodule

`default_nettype wire

// *** tb/rut_sva.sv ***
`timescale 1ns/100ps
`default_nettype none

// ----------
// timer bank checker
// ----------
module rut_sva
    import rut_pkg::*;
(
    // clock and reset
    input  wire logic                                  clk,
    input  wire logic                                  resetn,
    // controls
    input  wire logic      [NUM_TIMERS-1:0]            timer_start,
    input  wire logic      [NUM_TIMERS-1:0]            timer_stop,
    input  wire rut_mode_t [NUM_TIMERS-1:0]            timer_mode,
    input  wire logic [NUM_TIMERS-1:0][PRE_SEL_W-1:0]  prescale_sel,
    input  wire logic [NUM_TIMERS-1:0][CNT_W-1:0]      reload_value,
    input  wire logic      [NUM_TIMERS-1:0]            count_load,
    // status and pins
    input  wire logic [NUM_TIMERS-1:0][CNT_W-1:0]      count_value,
    input  wire logic      [NUM_TIMERS-1:0]            timer_irq,
    input  wire logic      [NUM_TIMERS-1:0]            timer_running,
    input  wire logic      [NUM_TIMERS-1:0]            timer_out,
    input  wire logic      [NUM_TIMERS-1:0]            timer_out_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // output pins form a complementary pair at all times
    out_pair_a: assert property (timer_out_n == ~timer_out)
        else $error("output pair not complementary");

    // per-timer relations
    for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_ch
        wire irq_nc = timer_irq[i] && timer_mode[i] != MODE_CAPTURE;

        irq_match_a: assert property (irq_nc |->
            $past(count_value[i]) == $past(reload_value[i]))
            else $error("interrupt without reload match");
        irq_start_a: assert property (irq_nc |->
            count_value[i] == CNT_START)
            else $error("count not back at start on reload");
        oneshot_stop_a: assert property (
            timer_irq[i] && timer_mode[i] == MODE_ONE_SHOT
            |-> !timer_running[i])
            else $error("single shot did not stop");
        cont_keep_a: assert property (
            timer_irq[i] && timer_mode[i] == MODE_CONTINUOUS
            && !$past(timer_stop[i]) |-> timer_running[i])
            else $error("continuous timer stopped on reload");
        count_step_a: assert property (
            timer_running[i] && !timer_irq[i] && $past(timer_running[i])
            && !$past(count_load[i]) && $changed(count_value[i])
            |-> count_value[i] == $past(count_value[i]) + CNT_STEP)
            else $error("count did not step by one");
        idle_hold_a: assert property (
            !timer_running[i] && !$past(timer_running[i])
            && !timer_irq[i] && !$past(count_load[i])
            |-> $stable(count_value[i]))
            else $error("idle count moved");
        start_run_a: assert property (
            timer_start[i] && !timer_stop[i]
            && timer_mode[i] inside {MODE_ONE_SHOT, MODE_CONTINUOUS}
            |=> timer_running[i])
            else $error("timer did not start");
        stop_halt_a: assert property (timer_stop[i] |=>
            !timer_running[i])
            else $error("timer did not stop");
        min_time_a: assert property (
            timer_start[i] && !timer_running[i] && !timer_stop[i]
            && timer_mode[i] == MODE_ONE_SHOT && prescale_sel[i] == 3'h0
            && reload_value[i] == CNT_START && count_value[i] == CNT_START
            |-> ##2 timer_irq[i])
            else $error("shortest time-out missed");
    end

    // main scenarios reached
    oneshot_c: cover property (timer_irq[0] && !timer_running[0]);
    wrap_c: cover property (count_value[0] == 16'hffff
        ##1 count_value[0] == 16'h0000);
    counter_c: cover property (timer_mode[1] == MODE_COUNTER
        && $changed(count_value[1]));
endmodule

`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/100ps
`default_nettype none

module tb
    import rut_pkg::*;
();
    // ----------
    // signals
    // ----------
    logic                                  clk, resetn;
    logic      [NUM_TIMERS-1:0]            timer_start;
    logic      [NUM_TIMERS-1:0]            timer_stop;
    rut_mode_t [NUM_TIMERS-1:0]            timer_mode;
    logic      [NUM_TIMERS-1:0][PRE_SEL_W-1:0] prescale_sel;
    logic      [NUM_TIMERS-1:0]            polarity;
    logic      [NUM_TIMERS-1:0][CNT_W-1:0] reload_value;
    logic      [NUM_TIMERS-1:0][CNT_W-1:0] pwm_compare;
    logic      [NUM_TIMERS-1:0]            count_load;
    logic      [NUM_TIMERS-1:0][CNT_W-1:0] count_load_value;
    logic                                  timer0_input_pin, timer1_input_pin;
    logic                                  timer2_input_pin, timer0_alt_enable;
    logic                                  timer0_alt_input_a;
    logic                                  timer0_alt_input_b;
    logic                                  timer0_alt_input_c;
    logic      [NUM_TIMERS-1:0][CNT_W-1:0] count_value;
    logic      [NUM_TIMERS-1:0][CNT_W-1:0] capture_value;
    logic      [NUM_TIMERS-1:0]            timer_irq;
    logic      [NUM_TIMERS-1:0]            timer_running;
    logic      [NUM_TIMERS-1:0]            timer_out;
    logic      [NUM_TIMERS-1:0]            timer_out_n;
    int                                    mismatches = 0, cmp_count = 0;

    rut_timer_bank dut (
        .clk, .resetn, .timer_start, .timer_stop, .timer_mode,
        .prescale_sel, .polarity, .reload_value, .pwm_compare,
        .count_load, .count_load_value, .timer0_input_pin,
        .timer1_input_pin, .timer2_input_pin, .timer0_alt_input_a,
        .timer0_alt_input_b, .timer0_alt_input_c, .timer0_alt_enable,
        .count_value, .capture_value, .timer_irq, .timer_running,
        .timer_out, .timer_out_n
    );

    // 100 MHz clock
    always #5 clk = ~clk;

    // ----------
    // helpers
    // ----------
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one-cycle strobe: 0 start, 1 stop, 2 load
    task automatic strobe(logic [2:0] m, int k);
        @(posedge clk);
        case (k)
            0: timer_start <= m;
            1: timer_stop <= m;
            default: count_load <= m;
        endcase
        @(posedge clk);
        timer_start <= '0;
        timer_stop <= '0;
        count_load <= '0;
    endtask

    task automatic cfg(int i, rut_mode_t md, logic [2:0] s, logic p,
                       logic [15:0] r);
        @(posedge clk);
        timer_mode[i] <= md;
        prescale_sel[i] <= s;
        polarity[i] <= p;
        reload_value[i] <= r;
    endtask

    // bounded wait for an interrupt, n = negedges taken
    task automatic wait_irq(int i, output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (timer_irq[i] !== 1'b1 && n < 400);
        if (timer_irq[i] !== 1'b1) begin
            mismatches++;
            $display("mismatch irq_wait expected 1 seen 0");
            end_sim();
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ----------
    // scenarios
    // ----------
    task automatic t_reset();
        @(negedge clk);
        for (int i = 0; i < NUM_TIMERS; i++) begin
            chk("count", count_value[i], 32'h0000_0001);
            chk("capture", capture_value[i], 32'h0);
            chk("irq", timer_irq[i], 1'h0);
            chk("run", timer_running[i], 1'h0);
            chk("out", timer_out[i], 1'h0);
            chk("out_n", timer_out_n[i], 1'h1);
        end
        $display("test reset done");
    endtask

    // timer 0 reload 3 walk, timer 1 shortest time-out
    task automatic t_oneshot();
        logic [4:0] e [5] = '{5'b01000, 5'b00111, 5'b01000, 5'b00010,
                              5'b00001};
        logic [15:0] c0 [5] = '{16'h0001, 16'h0002, 16'h0003, 16'h0001,
                                16'h0001};
        cfg(0, MODE_ONE_SHOT, 3'h0, 1'h0, 16'h0003);
        cfg(1, MODE_ONE_SHOT, 3'h0, 1'h0, 16'h0001);
        strobe(3'h3, 0);
        for (int k = 0; k < 5; k++) begin
            @(negedge clk);
            chk("count0", count_value[0], c0[k]);
            chk("irq0", timer_irq[0], e[0][k]);
            chk("run0", timer_running[0], e[1][k]);
            chk("out0", timer_out[0], e[2][k]);
            chk("count1", count_value[1], 32'h0000_0001);
            chk("irq1", timer_irq[1], e[3][k]);
            chk("run1", timer_running[1], e[4][k]);
        end
        repeat (10) @(negedge clk);
        chk("stay0", timer_running[0], 1'h0);
        chk("stay1", count_value[1], 32'h0000_0001);
        $display("test oneshot done");
    endtask

    // timer 2 continuous, reload 1, every prescale setting
    task automatic t_prescale();
        int  n;
        logic o;
        for (int s = 0; s < 8; s++) begin
            cfg(2, MODE_CONTINUOUS, s[2:0], 1'h0, 16'h0001);
            strobe(3'h4, 0);
            wait_irq(2, n);
            o = timer_out[2];
            wait_irq(2, n);
            chk("period", n, 32'h1 << s);
            chk("toggle", timer_out[2], !o);
            chk("keep", timer_running[2], 1'h1);
            strobe(3'h4, 1);
        end
        $display("test prescale done");
    endtask

    // full period and reload below count, both through the wrap
    task automatic t_wrap();
        logic [15:0] rl [2] = '{16'h0000, 16'h0002};
        logic [15:0] e;
        logic        hit;
        for (int c = 0; c < 2; c++) begin
            cfg(0, MODE_CONTINUOUS, 3'h0, 1'h0, rl[c]);
            count_load_value[0] <= 16'hfffe;
            strobe(3'h1, 2);
            strobe(3'h1, 0);
            e = 16'hfffe;
            @(negedge clk);
            chk("first", count_value[0], e);
            for (int k = 0; k < 6; k++) begin
                @(negedge clk);
                hit = (e == rl[c]);
                e = hit ? 16'h0001 : e + 16'h0001;
                chk("wrap", count_value[0], e);
                chk("wrap_irq", timer_irq[0], hit);
            end
            strobe(3'h1, 1);
        end
        $display("test wrap done");
    endtask

    // event counting on every input, timer 0 alternates
    task automatic t_inputs();
        cfg(0, MODE_COUNTER, 3'h0, 1'h0, 16'hffff);
        cfg(1, MODE_COUNTER, 3'h0, 1'h0, 16'hffff);
        cfg(2, MODE_COUNTER, 3'h0, 1'h1, 16'hffff);
        count_load_value <= {3{16'h0010}};
        strobe(3'h7, 2);
        strobe(3'h7, 0);
        for (int j = 0; j < 5; j++) begin
            @(posedge clk);
            timer0_alt_enable <= (j < 4);
            timer0_input_pin <= (j == 0);
            timer0_alt_input_a <= (j == 1 || j == 4);
            timer0_alt_input_b <= (j == 2);
            timer0_alt_input_c <= (j == 3);
            timer1_input_pin <= 1'b1;
            timer2_input_pin <= 1'b1;
            repeat (5) @(posedge clk);
            {timer0_input_pin, timer0_alt_input_a, timer0_alt_input_b,
             timer0_alt_input_c, timer1_input_pin, timer2_input_pin} <= '0;
            repeat (6) @(posedge clk);
        end
        @(negedge clk);
        chk("events0", count_value[0], 32'h0000_0014);
        chk("events1", count_value[1], 32'h0000_0015);
        chk("events2", count_value[2], 32'h0000_0015);
        // capture through an alternate input, prescaler slow
        cfg(0, MODE_CAPTURE, 3'h7, 1'h0, 16'hffff);
        timer0_alt_enable <= 1'b1;
        timer0_alt_input_b <= 1'b1;
        repeat (6) @(negedge clk);
        chk("capture0", capture_value[0], 32'h0000_0014);
        strobe(3'h7, 1);
        $display("test inputs done");
    endtask

    // ----------
    // main sequence
    // ----------
    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        timer_mode = '{default: MODE_ONE_SHOT};
        {timer_start, timer_stop, prescale_sel, polarity, reload_value,
         pwm_compare, count_load, count_load_value} = '0;
        {timer0_input_pin, timer1_input_pin, timer2_input_pin,
         timer0_alt_input_a, timer0_alt_input_b, timer0_alt_input_c,
         timer0_alt_enable} = '0;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_oneshot();
        t_prescale();
        t_wrap();
        t_inputs();
        end_sim();
    end
endmodule

bind rut_timer_bank rut_sva u_sva (
    .clk, .resetn, .timer_start, .timer_stop, .timer_mode, .prescale_sel,
    .reload_value, .count_load, .count_value, .timer_irq, .timer_running,
    .timer_out, .timer_out_n
);

`default_nettype wire
